// *** logic/adc_status_pkg.sv ***
// Constants for the converter status, result and interrupt register block
// Operation
// - Channel state register bit reads 1 when channel enabled, 0 when disabled
// - Status layout: done 7:0, overrun 15:8, ready 16, global 17, end 18, full 19
// - Buffer full flag is 1 exactly when both receive counters are zero
// - Buffer end flag sets when current counter steps down from 1, clears on counter write
// - Global overrun flag sets on error, clears when status register is read
// - Ready flag sets on conversion done, clears on last result read
// - Channel overrun flag sets on channel error, clears on status read
// - Channel done flag is 1 only while enabled and conversion completed
// - Last result captures 10-bit result at every conversion end
// - Channel result loads at conversion end only when channel enabled
// - Writing 1 to interrupt enable set register sets mask bit
// - Writing 1 to interrupt enable clear register clears mask bit
// - Mask state register reads enabled sources at status bit positions
// - Channel on set register enables, clear register disables, zeros ignored
package adc_status_pkg;
  localparam int          NUM_CH           = 8;
  localparam int          RES_W            = 10;
  localparam int          CNT_W            = 16;
  localparam int          FLAG_W           = 20;
  // Byte offsets
  localparam logic [7:0]  OFS_CH_ON_SET    = 8'h10;
  localparam logic [7:0]  OFS_CH_ON_CLR    = 8'h14;
  localparam logic [7:0]  OFS_CH_STATE     = 8'h18;
  localparam logic [7:0]  OFS_STATUS       = 8'h1c;
  localparam logic [7:0]  OFS_LAST         = 8'h20;
  localparam logic [7:0]  OFS_IRQ_SET      = 8'h24;
  localparam logic [7:0]  OFS_IRQ_CLR      = 8'h28;
  localparam logic [7:0]  OFS_IRQ_MASK     = 8'h2c;
  localparam logic [7:0]  OFS_CH_RES0      = 8'h30;
  localparam logic [7:0]  OFS_CH_RES7      = 8'h4c;
  localparam logic [7:0]  OFS_RX_CUR       = 8'h80;
  localparam logic [7:0]  OFS_RX_NEXT      = 8'h84;
  localparam logic [7:0]  OFS_VERSION      = 8'hfc;
  // Status field positions
  localparam int          POS_DONE         = 0;
  localparam int          POS_OVR          = 8;
  localparam int          POS_READY        = 16;
  localparam int          POS_GLOBAL       = 17;
  localparam int          POS_END          = 18;
  localparam int          POS_FULL         = 19;
  // Reset values
  localparam logic [31:0] RST_STATUS       = 32'h000c0000;
  localparam logic [31:0] RST_ZERO         = 32'h00000000;
  localparam logic [CNT_W-1:0] RST_COUNT   = 16'h0000;
  // Version value is arbitrary
  localparam logic [31:0] VERSION_VALUE    = 32'h00000100;
endpackage : adc_status_pkg

// *** logic/adc_status_regs.sv ***
// Status, result and interrupt mask registers of the converter, APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module adc_status_regs (
  input  wire logic                                clock_i,
  input  wire logic                                rst_b_i,
  input  wire logic                                psel_i,
  input  wire logic                                penable_i,
  input  wire logic                                pwrite_i,
  input  wire logic [7:0]                          paddr_i,
  input  wire logic [31:0]                         pwdata_i,
  output logic      [31:0]                         prdata_o,
  output logic                                     pready_o,
  output logic                                     pslverr_o,
  input  wire logic                                conv_done_i,
  input  wire logic [2:0]                          conv_chan_i,
  input  wire logic [adc_status_pkg::RES_W-1:0]    conv_data_i,
  input  wire logic [adc_status_pkg::NUM_CH-1:0]   chan_overrun_i,
  input  wire logic                                global_overrun_i,
  input  wire logic                                rx_dec_i,
  output logic      [adc_status_pkg::NUM_CH-1:0]   channel_on_o,
  output logic      [adc_status_pkg::CNT_W-1:0]    rx_count_current_o,
  output logic                                     irq_o
);
  localparam int N = adc_status_pkg::NUM_CH;
  localparam int FW = adc_status_pkg::FLAG_W;

  typedef enum logic [1:0] {IDLE, READ_WAIT, DONE} bus_state_type;

  bus_state_type                      state;
  logic [N-1:0]                       channel_on;
  logic [N-1:0]                       channel_done_flag;
  logic [N-1:0]                       channel_overrun_flag;
  logic                               result_ready_flag;
  logic                               global_overrun_flag;
  logic                               rx_buffer_end_flag;
  logic                               rx_buffer_full_flag;
  logic [adc_status_pkg::CNT_W-1:0]   rx_count_current;
  logic [adc_status_pkg::CNT_W-1:0]   rx_count_next;
  logic [adc_status_pkg::RES_W-1:0]   last_result_value;
  logic [FW-1:0]                      irq_mask;
  logic [FW-1:0]                      status_flags;
  logic [adc_status_pkg::RES_W-1:0]   bank_data;
  logic [2:0]                         bank_sel;
  logic                               wr_strobe;
  logic                               rd_strobe;
  logic                               mapped;
  logic                               rd_status;
  logic                               rd_last;
  logic                               wr_cur;
  logic                               wr_next;
  logic                               wr_ch_set;
  logic                               wr_ch_clr;
  logic                               wr_irq_set;
  logic                               wr_irq_clr;
  logic                               late_result;
  logic [31:0]                        next_rdata;

  // Address decode used for both mapping check and read mux
  function automatic logic is_result(input logic [7:0] a);
    return a >= adc_status_pkg::OFS_CH_RES0 && a <= adc_status_pkg::OFS_CH_RES7
           && a[1:0] == 2'b00;
  endfunction : is_result

  // Accesses complete on the second access cycle for results, otherwise at once
  assign wr_strobe = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_strobe = psel_i && penable_i && !pwrite_i && pready_o;
  assign rd_status = rd_strobe && paddr_i == adc_status_pkg::OFS_STATUS;
  assign rd_last   = rd_strobe && paddr_i == adc_status_pkg::OFS_LAST;
  assign wr_cur    = wr_strobe && paddr_i == adc_status_pkg::OFS_RX_CUR;
  assign wr_next   = wr_strobe && paddr_i == adc_status_pkg::OFS_RX_NEXT;
  assign wr_ch_set  = wr_strobe && paddr_i == adc_status_pkg::OFS_CH_ON_SET;
  assign wr_ch_clr  = wr_strobe && paddr_i == adc_status_pkg::OFS_CH_ON_CLR;
  assign wr_irq_set = wr_strobe && paddr_i == adc_status_pkg::OFS_IRQ_SET;
  assign wr_irq_clr = wr_strobe && paddr_i == adc_status_pkg::OFS_IRQ_CLR;
  assign bank_sel  = paddr_i[4:2] - 3'(adc_status_pkg::OFS_CH_RES0 >> 2);

  always_comb begin
    unique case (paddr_i)
      adc_status_pkg::OFS_CH_ON_SET, adc_status_pkg::OFS_CH_ON_CLR,
      adc_status_pkg::OFS_IRQ_SET, adc_status_pkg::OFS_IRQ_CLR,
      adc_status_pkg::OFS_RX_CUR, adc_status_pkg::OFS_RX_NEXT: mapped = 1'b1;
      adc_status_pkg::OFS_CH_STATE, adc_status_pkg::OFS_STATUS,
      adc_status_pkg::OFS_LAST, adc_status_pkg::OFS_IRQ_MASK,
      adc_status_pkg::OFS_VERSION: mapped = !pwrite_i;
      default: mapped = is_result(paddr_i) && !pwrite_i;
    endcase
  end

  // Ready: one wait state on result reads while the bank output settles
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE: begin
          if (psel_i && !penable_i && !pwrite_i && is_result(paddr_i)) begin
            state <= READ_WAIT;
          end
        end
        READ_WAIT: state <= DONE;
        DONE: state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  always_comb begin
    pready_o  = !(psel_i && !pwrite_i && is_result(paddr_i)) || state == DONE;
    pslverr_o = psel_i && penable_i && pready_o && !mapped;
  end

  // Channel enable state
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      channel_on <= '0;
    end else if (wr_ch_set) begin
      channel_on <= channel_on | pwdata_i[N-1:0];
    end else if (wr_ch_clr) begin
      channel_on <= channel_on & ~pwdata_i[N-1:0];
    end
  end

  // Per-channel done flags; dropped when the channel is disabled
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_done
      always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
          channel_done_flag[g] <= 1'b0;
        end else if (!channel_on[g]) begin
          channel_done_flag[g] <= 1'b0;
        end else if (conv_done_i && conv_chan_i == 3'(g)) begin
          channel_done_flag[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Channel overrun: a status read clears only the bits it reported; set wins
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      channel_overrun_flag <= '0;
    end else if (rd_status) begin
      channel_overrun_flag <= chan_overrun_i | (channel_overrun_flag
        & ~prdata_o[adc_status_pkg::POS_OVR +: N]);
    end else begin
      channel_overrun_flag <= channel_overrun_flag | chan_overrun_i;
    end
  end

  // Global overrun, cleared only when the read reported it; set wins
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      global_overrun_flag <= 1'b0;
    end else if (rd_status && prdata_o[adc_status_pkg::POS_GLOBAL]) begin
      global_overrun_flag <= global_overrun_i;
    end else begin
      global_overrun_flag <= global_overrun_flag | global_overrun_i;
    end
  end

  // Last converted value, kept until the next conversion ends
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      last_result_value <= '0;
    end else if (conv_done_i) begin
      last_result_value <= conv_data_i;
    end
  end

  // A result landing at a setup edge is missing from that read's data
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      late_result <= 1'b0;
    end else begin
      late_result <= conv_done_i && psel_i && !penable_i;
    end
  end

  // Ready flag: a new result wins over the read that clears it
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      result_ready_flag <= 1'b0;
    end else begin
      result_ready_flag <= conv_done_i
                           | (result_ready_flag && !(rd_last && !late_result));
    end
  end

  // Current receive counter: reloads from the next counter when it runs out
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rx_count_current <= adc_status_pkg::RST_COUNT;
    end else if (wr_cur) begin
      rx_count_current <= pwdata_i[adc_status_pkg::CNT_W-1:0];
    end else if (rx_dec_i && rx_count_current != '0) begin
      if (rx_count_current == 16'h0001 && rx_count_next != '0) begin
        rx_count_current <= rx_count_next;
      end else begin
        rx_count_current <= rx_count_current - 16'h0001;
      end
    end
  end

  // Next receive counter: emptied once handed over, kept if current is rewritten
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rx_count_next <= adc_status_pkg::RST_COUNT;
    end else if (wr_next) begin
      rx_count_next <= pwdata_i[adc_status_pkg::CNT_W-1:0];
    end else if (rx_dec_i && rx_count_current == 16'h0001 && !wr_cur) begin
      rx_count_next <= '0;
    end
  end

  // End flag: a step down from 1 of the current counter wins over a counter write in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rx_buffer_end_flag <= adc_status_pkg::RST_STATUS[adc_status_pkg::POS_END];
    end else if (rx_dec_i && rx_count_current == 16'h0001) begin
      rx_buffer_end_flag <= 1'b1;
    end else if (wr_cur || wr_next) begin
      rx_buffer_end_flag <= 1'b0;
    end
  end

  assign rx_buffer_full_flag = rx_count_current == '0 && rx_count_next == '0;

  // Status word layout
  always_comb begin
    status_flags = '0;
    status_flags[adc_status_pkg::POS_DONE +: N] = channel_done_flag & channel_on;
    status_flags[adc_status_pkg::POS_OVR +: N]  = channel_overrun_flag;
    status_flags[adc_status_pkg::POS_READY]     = result_ready_flag;
    status_flags[adc_status_pkg::POS_GLOBAL]    = global_overrun_flag;
    status_flags[adc_status_pkg::POS_END]       = rx_buffer_end_flag;
    status_flags[adc_status_pkg::POS_FULL]      = rx_buffer_full_flag;
  end

  // Interrupt mask: set has priority over clear within one write
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_mask <= '0;
    end else if (wr_irq_set) begin
      irq_mask <= irq_mask | pwdata_i[FW-1:0];
    end else if (wr_irq_clr) begin
      irq_mask <= irq_mask & ~pwdata_i[FW-1:0];
    end
  end

  // Registered interrupt line
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_flags & irq_mask);
    end
  end

  channel_result_bank u_bank (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .done_i     (conv_done_i),
    .chan_i     (conv_chan_i),
    .data_i     (conv_data_i),
    .enabled_i  (channel_on),
    .sel_i      (bank_sel),
    .sel_data_o (bank_data)
  );

  // Read mux; unused upper bits stay zero
  always_comb begin
    next_rdata = '0;
    unique case (paddr_i)
      adc_status_pkg::OFS_CH_STATE: next_rdata[N-1:0] = channel_on;
      adc_status_pkg::OFS_STATUS:   next_rdata[FW-1:0] = status_flags;
      adc_status_pkg::OFS_LAST:     next_rdata[adc_status_pkg::RES_W-1:0] = last_result_value;
      adc_status_pkg::OFS_IRQ_MASK: next_rdata[FW-1:0] = irq_mask;
      adc_status_pkg::OFS_RX_CUR:   next_rdata[adc_status_pkg::CNT_W-1:0] = rx_count_current;
      adc_status_pkg::OFS_RX_NEXT:  next_rdata[adc_status_pkg::CNT_W-1:0] = rx_count_next;
      adc_status_pkg::OFS_VERSION:  next_rdata = adc_status_pkg::VERSION_VALUE;
      default: begin
        if (is_result(paddr_i)) begin
          next_rdata[adc_status_pkg::RES_W-1:0] = bank_data;
        end
      end
    endcase
  end

  // Read data register, loaded in the setup and wait cycles
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      prdata_o <= adc_status_pkg::RST_ZERO;
    end else if (psel_i && !pwrite_i && !pready_o) begin
      prdata_o <= next_rdata;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end

  assign channel_on_o       = channel_on;
  assign rx_count_current_o = rx_count_current;
endmodule : adc_status_regs

// *** logic/channel_result_bank.sv ***
// Per-channel result storage
`timescale 1ns/10ps
module channel_result_bank (
  input  wire logic                                   clock_i,
  input  wire logic                                   rst_b_i,
  input  wire logic                                   done_i,
  input  wire logic [2:0]                             chan_i,
  input  wire logic [adc_status_pkg::RES_W-1:0]       data_i,
  input  wire logic [adc_status_pkg::NUM_CH-1:0]      enabled_i,
  input  wire logic [2:0]                             sel_i,
  output logic      [adc_status_pkg::RES_W-1:0]       sel_data_o
);
  logic [adc_status_pkg::RES_W-1:0] result [adc_status_pkg::NUM_CH];

  // Load a slot only when its channel is enabled
  genvar g;
  generate
    for (g = 0; g < adc_status_pkg::NUM_CH; g++) begin : g_slot
      always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
          result[g] <= '0;
        end else if (done_i && chan_i == 3'(g) && enabled_i[g]) begin
          result[g] <= data_i;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sel_data_o <= '0;
    end else begin
      sel_data_o <= result[sel_i];
    end
  end
endmodule : channel_result_bank

// *** tb/adc_status_regs_chk.sv ***
// Port-level checks for the converter register block
`timescale 1ns/10ps
module adc_status_regs_chk (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rx_dec_i,
  input wire logic        irq_o,
  input wire logic [7:0]  channel_on_o,
  input wire logic [15:0] rx_count_current_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Completed transfers and result window
  wire logic wr  = psel_i && penable_i && pready_o && pwrite_i;
  wire logic rd  = psel_i && penable_i && pready_o && !pwrite_i;
  wire logic res = paddr_i >= adc_status_pkg::OFS_CH_RES0
                   && paddr_i <= adc_status_pkg::OFS_CH_RES7;
  wire logic set = wr && paddr_i == adc_status_pkg::OFS_CH_ON_SET;
  wire logic clr = wr && paddr_i == adc_status_pkg::OFS_CH_ON_CLR;
  wire logic cur = wr && paddr_i == adc_status_pkg::OFS_RX_CUR;
  property p_on_set; set |=> channel_on_o == ($past(channel_on_o) | $past(pwdata_i[7:0]));
  endproperty
  a_on_set: assert property (p_on_set) else $error("channel set write lost");
  property p_on_clr; clr |=> channel_on_o == ($past(channel_on_o) & ~$past(pwdata_i[7:0]));
  endproperty
  a_on_clr: assert property (p_on_clr) else $error("channel clear write lost");
  property p_on_hold; !(set || clr) |=> $stable(channel_on_o); endproperty
  a_on_hold: assert property (p_on_hold) else $error("channel enables moved alone");
  property p_state; rd && paddr_i == adc_status_pkg::OFS_CH_STATE
    |-> prdata_o == {24'h0, channel_on_o}; endproperty
  a_state: assert property (p_state) else $error("channel state read wrong");
  property p_ro_err; psel_i && penable_i && pwrite_i && paddr_i == adc_status_pkg::OFS_STATUS
    |-> pslverr_o && pready_o; endproperty
  a_ro_err: assert property (p_ro_err) else $error("status write not refused");
  property p_cnt_wr; cur && !rx_dec_i |=> rx_count_current_o == $past(pwdata_i[15:0]); endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");
  property p_cnt_dec; rx_dec_i && rx_count_current_o > 16'h0001 && !cur
    |=> rx_count_current_o == $past(rx_count_current_o) - 16'h0001; endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("counter did not step down");
  property p_res_wait; psel_i && penable_i && !pwrite_i && res && !$past(penable_i)
    |-> !pready_o ##1 pready_o; endproperty
  a_res_wait: assert property (p_res_wait) else $error("result read timing wrong");
  c_res: cover property (rd && res);
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pslverr_o && pready_o);
endmodule : adc_status_regs_chk

bind adc_status_regs adc_status_regs_chk adc_status_regs_chk_inst (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_dec_i(rx_dec_i), .irq_o(irq_o),
  .channel_on_o(channel_on_o), .rx_count_current_o(rx_count_current_o));

// *** tb/adc_status_regs_tb_top.sv ***
// Self-checking bench for the converter register block
`timescale 1ns/10ps
module adc_status_regs_tb_top;
  logic        clock_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        conv_done_i, global_overrun_i, rx_dec_i, irq_o, e;
  logic [7:0]  paddr_i, chan_overrun_i, channel_on_o, chm;
  logic [31:0] pwdata_i, prdata_o, seed, q, m;
  logic [2:0]  conv_chan_i;
  logic [9:0]  conv_data_i, d;
  logic [15:0] rx_count_current_o;
  int          error_cnt, cmp_count;
  adc_status_regs adc_status_regs_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .conv_done_i(conv_done_i),
    .conv_chan_i(conv_chan_i), .conv_data_i(conv_data_i), .chan_overrun_i(chan_overrun_i),
    .global_overrun_i(global_overrun_i), .rx_dec_i(rx_dec_i), .channel_on_o(channel_on_o),
    .rx_count_current_o(rx_count_current_o), .irq_o(irq_o));
  // Clock at 40 ns
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] fb(input int pos);
    return 32'h1 << pos;
  endfunction : fb
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // One transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock_i);
    end
    if (n == 20) error_cnt++;
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    cmp(q & msk, exp);
  endtask : rd
  // One-cycle pulses on the side inputs
  task automatic strobe(input logic dn, input logic [2:0] c, input logic [9:0] v,
                        input logic [7:0] ov, input logic g, input logic dc);
    conv_done_i <= dn;
    conv_chan_i <= c;
    conv_data_i <= v;
    chan_overrun_i <= ov;
    global_overrun_i <= g;
    rx_dec_i <= dc;
    @(posedge clock_i);
    {conv_done_i, chan_overrun_i, global_overrun_i, rx_dec_i} <= 11'h0;
    @(posedge clock_i);
  endtask : strobe
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // Watchdog
  initial begin
    repeat (5000) @(posedge clock_i);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
  // Main sequence
  initial begin
    {rst_b_i, psel_i, penable_i, pwrite_i, conv_done_i, global_overrun_i, rx_dec_i} = 7'h0;
    {paddr_i, pwdata_i, conv_chan_i, conv_data_i, chan_overrun_i} = 61'h0;
    {error_cnt, cmp_count, seed, chm, m} = {32'h0, 32'h0, 32'h2f51, 8'h0, 32'h0};
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    rd(adc_status_pkg::OFS_STATUS, 32'h000c0000, 32'hffffffff);
    rd(adc_status_pkg::OFS_LAST, 32'h0, 32'hffffffff);
    rd(adc_status_pkg::OFS_IRQ_MASK, 32'h0, 32'hffffffff);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      apb(1'b1, adc_status_pkg::OFS_CH_ON_SET, seed);
      chm |= seed[7:0];
      seed = lfsr(seed);
      apb(1'b1, adc_status_pkg::OFS_CH_ON_CLR, seed);
      chm &= ~seed[7:0];
      rd(adc_status_pkg::OFS_CH_STATE, {24'h0, chm}, 32'hffffffff);
      cmp({24'h0, channel_on_o}, {24'h0, chm});
    end
    apb(1'b1, adc_status_pkg::OFS_CH_ON_SET, 32'h7f);
    apb(1'b1, adc_status_pkg::OFS_CH_ON_CLR, 32'h80);
    $display("channel enables done");
    d = seed[9:0];
    strobe(1'b1, 3'd3, d, 8'h0, 1'b0, 1'b0);
    rd(adc_status_pkg::OFS_STATUS, fb(16) | fb(3), fb(16) | fb(3));
    rd(adc_status_pkg::OFS_LAST, {22'h0, d}, 32'hffffffff);
    rd(adc_status_pkg::OFS_STATUS, 32'h0, fb(16));
    rd(adc_status_pkg::OFS_CH_RES0 + 8'h0c, {22'h0, d}, 32'hffffffff);
    strobe(1'b1, 3'd7, ~d, 8'h0, 1'b0, 1'b0);
    rd(adc_status_pkg::OFS_CH_RES7, 32'h0, 32'hffffffff);
    rd(adc_status_pkg::OFS_STATUS, fb(16), fb(16) | fb(7));
    rd(adc_status_pkg::OFS_LAST, {22'h0, ~d}, 32'hffffffff);
    apb(1'b1, adc_status_pkg::OFS_CH_ON_CLR, 32'h8);
    rd(adc_status_pkg::OFS_STATUS, 32'h0, fb(3));
    $display("conversions done");
    strobe(1'b0, 3'd0, 10'h0, seed[15:8] | 8'h01, 1'b1, 1'b0);
    rd(adc_status_pkg::OFS_STATUS, fb(17) | {16'h0, seed[15:8] | 8'h01, 8'h0},
       32'h2ff00);
    rd(adc_status_pkg::OFS_STATUS, 32'h0, 32'h2ff00);
    $display("overruns done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      apb(1'b1, adc_status_pkg::OFS_IRQ_SET, seed);
      m |= seed & 32'h000fffff;
      seed = lfsr(seed);
      apb(1'b1, adc_status_pkg::OFS_IRQ_CLR, seed);
      m &= ~seed;
      rd(adc_status_pkg::OFS_IRQ_MASK, m, 32'hffffffff);
    end
    apb(1'b1, adc_status_pkg::OFS_IRQ_CLR, 32'hffffffff);
    strobe(1'b1, 3'd0, d, 8'h0, 1'b0, 1'b0);
    repeat (2) @(posedge clock_i);
    cmp({31'h0, irq_o}, 32'h0);
    apb(1'b1, adc_status_pkg::OFS_IRQ_SET, fb(16));
    repeat (2) @(posedge clock_i);
    cmp({31'h0, irq_o}, 32'h1);
    rd(adc_status_pkg::OFS_LAST, {22'h0, d}, 32'hffffffff);
    repeat (2) @(posedge clock_i);
    cmp({31'h0, irq_o}, 32'h0);
    $display("interrupt mask done");
    apb(1'b1, adc_status_pkg::OFS_RX_NEXT, 32'h0);
    apb(1'b1, adc_status_pkg::OFS_RX_CUR, 32'h2);
    rd(adc_status_pkg::OFS_STATUS, 32'h0, fb(18) | fb(19));
    strobe(1'b0, 3'd0, 10'h0, 8'h0, 1'b0, 1'b1);
    strobe(1'b0, 3'd0, 10'h0, 8'h0, 1'b0, 1'b1);
    rd(adc_status_pkg::OFS_STATUS, fb(18) | fb(19), fb(18) | fb(19));
    apb(1'b1, adc_status_pkg::OFS_RX_CUR, 32'h1);
    apb(1'b1, adc_status_pkg::OFS_RX_NEXT, 32'h3);
    rd(adc_status_pkg::OFS_STATUS, 32'h0, fb(18) | fb(19));
    strobe(1'b0, 3'd0, 10'h0, 8'h0, 1'b0, 1'b1);
    cmp({16'h0, rx_count_current_o}, 32'h3);
    rd(adc_status_pkg::OFS_STATUS, fb(18), fb(18) | fb(19));
    rd(adc_status_pkg::OFS_RX_CUR, 32'h3, 32'hffffffff);
    rd(adc_status_pkg::OFS_RX_NEXT, 32'h0, 32'hffffffff);
    $display("receive counters done");
    rd(adc_status_pkg::OFS_VERSION, adc_status_pkg::VERSION_VALUE, 32'hffffffff);
    cmp({31'h0, e}, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    cmp({31'h0, e}, 32'h1);
    apb(1'b1, adc_status_pkg::OFS_STATUS, 32'hffffffff);
    cmp({31'h0, e}, 32'h1);
    $display("refusals done");
    close_out();
  end
endmodule : adc_status_regs_tb_top
